// ===== bench/caa_alarm_aggregator_test.sv
`timescale 1ns/1ps
`include "caa_cfg.svh"
module caa_alarm_aggregator_test;
    import caa_pkg::*;
    logic        ref_clk, resetn;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready;
    caa_word_t   s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    caa_lanes_t  laneFifoErr, laneActive;
    logic        pllLocked, linkInDataState, linkStartup, linkRealign;
    logic        sysrefRealign, oscSync, oscPhaseMismatch, dividerMismatch;
    logic        status_output_pin, link_enable, irq;
    int          n_errors, checks, cyc, b;
    caa_word_t   d;
    logic [1:0]  r;

    caa_alarm_aggregator dut (.ref_clk, .resetn, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .laneFifoErr, .laneActive, .pllLocked, .linkInDataState,
        .linkStartup, .linkRealign, .sysrefRealign, .oscSync,
        .oscPhaseMismatch, .dividerMismatch, .status_output_pin,
        .link_enable, .irq);

    initial ref_clk = 1'b0;
    always #5 ref_clk = ~ref_clk;

    // registers sit on word indices, so the byte address is index times four
    function automatic logic [11:0] ba(input logic [9:0] idx);
        return {idx, 2'b00};
    endfunction

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
        end
    endtask

    // each valid drops only at the edge where its own ready was seen
    task automatic wr(input logic [9:0] idx, input logic [31:0] v);
        @(posedge ref_clk);
        s_axi_awaddr <= ba(idx);
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk({30'h0, s_axi_bresp}, {30'h0, `CAA_RESP_OKAY});
    endtask

    task automatic rd(input logic [11:0] a);
        @(posedge ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    task automatic rd_chk(input logic [9:0] idx, input logic [31:0] e);
        rd(ba(idx));
        chk(d, e);
        chk({30'h0, r}, {30'h0, `CAA_RESP_OKAY});
    endtask

    task automatic idle;
        dividerMismatch <= 1'b0;
        oscPhaseMismatch <= 1'b0;
        sysrefRealign <= 1'b0;
        linkInDataState <= 1'b1;
        pllLocked <= 1'b1;
        laneFifoErr <= '0;
        oscSync <= 1'b0;
        linkRealign <= 1'b0;
        linkStartup <= 1'b0;
    endtask

    // one-cycle event; the level sources return to their quiet value
    task automatic fire(input int k);
        @(posedge ref_clk);
        case (k)
            0: dividerMismatch <= 1'b1;
            1: oscPhaseMismatch <= 1'b1;
            2: sysrefRealign <= 1'b1;
            3: linkInDataState <= 1'b0;
            4: pllLocked <= 1'b0;
            5: laneFifoErr <= 16'h0008;
            6: oscSync <= 1'b1;
            7: linkRealign <= 1'b1;
            default: linkStartup <= 1'b1;
        endcase
        @(posedge ref_clk);
        idle();
    endtask

    initial begin
        resetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'b000;
        {s_axi_arvalid, s_axi_rready} = 2'b00;
        s_axi_awaddr = '0;
        s_axi_araddr = '0;
        s_axi_wdata = '0;
        s_axi_wstrb = 4'hf;
        laneActive = 16'h0008;
        idle();
        repeat (2) @(posedge ref_clk);
        resetn <= 1'b1;
        rd_chk(`CAA_IDX_FLAGS, 32'h3f);
        rd_chk(`CAA_IDX_MASK, 32'h3f);
        rd_chk(`CAA_IDX_SUMMARY, 32'h0);
        rd_chk(`CAA_IDX_LANE, 32'hffff);
        rd(12'hb0c);
        chk(d, 32'h0);
        chk({30'h0, r}, {30'h0, `CAA_RESP_SLVERR});
        $display("test reset done");
        wr(`CAA_IDX_CTRL, 32'h3);
        // the copy is registered one cycle after ctrl_r, on the edge where bvalid is seen
        @(negedge ref_clk);
        chk({31'h0, link_enable}, 32'h1);
        wr(`CAA_IDX_FLAGS, 32'h3f);
        wr(`CAA_IDX_LANE, 32'hffff);
        wr(`CAA_IDX_MASK, 32'h0);
        rd_chk(`CAA_IDX_FLAGS, 32'h0);
        for (int k = 0; k < 9; k++) begin
            b = (k < 6) ? k : ((k == 6) ? 1 : 3);
            // the 64b/66b sources only count once that mode is selected
            if (k == 7) begin
                wr(`CAA_IDX_CTRL, 32'h7);
                wr(`CAA_IDX_FLAGS, 32'h3f);
            end
            fire(k);
            rd_chk(`CAA_IDX_FLAGS, 32'h1 << b);
            rd_chk(`CAA_IDX_SUMMARY, 32'h1);
            chk({31'h0, status_output_pin}, 32'h1);
            if (k == 5) rd_chk(`CAA_IDX_LANE, 32'h8);
            wr(`CAA_IDX_MASK, 32'h1 << b);
            rd_chk(`CAA_IDX_SUMMARY, 32'h0);
            wr(`CAA_IDX_MASK, 32'h0);
            wr(`CAA_IDX_FLAGS, 32'h1 << b);
            rd_chk(`CAA_IDX_FLAGS, 32'h0);
            if (k == 5) rd_chk(`CAA_IDX_LANE, 32'h0);
            rd_chk(`CAA_IDX_SUMMARY, 32'h0);
            chk({31'h0, status_output_pin}, 32'h0);
        end
        @(posedge ref_clk);
        pllLocked <= 1'b0;
        wr(`CAA_IDX_FLAGS, 32'h10);
        rd_chk(`CAA_IDX_FLAGS, 32'h10);
        idle();
        wr(`CAA_IDX_FLAGS, 32'h10);
        rd_chk(`CAA_IDX_FLAGS, 32'h0);
        $display("test events done");
        chk({31'h0, irq}, 32'h0);
        rd_chk(`CAA_IDX_IRQSTAT, 32'h3);
        rd_chk(`CAA_IDX_IRQSTAT, 32'h0);
        wr(`CAA_IDX_IRQMASK, 32'h3);
        fire(0);
        rd_chk(`CAA_IDX_SUMMARY, 32'h1);
        wr(`CAA_IDX_CTRL, 32'h6);
        rd_chk(`CAA_IDX_CTRL, 32'h6);
        chk({31'h0, status_output_pin}, 32'h0);
        chk({31'h0, irq}, 32'h1);
        rd_chk(`CAA_IDX_IRQSTAT, 32'h1);
        wr(`CAA_IDX_FLAGS, 32'h1);
        chk({31'h0, irq}, 32'h0);
        $display("test interrupt done");
        wr(`CAA_IDX_CTRL, 32'hf);
        rd_chk(`CAA_IDX_FLAGS, 32'h3f);
        rd_chk(`CAA_IDX_MASK, 32'h3f);
        $display("test soft reset done");
        tally_and_finish();
    end
endmodule

// ===== hdl/caa_alarm_aggregator.sv
`timescale 1ns/1ps
`include "caa_cfg.svh"
module caa_alarm_aggregator
    import caa_pkg::*;
(
    // clock and reset
    input  wire logic              ref_clk,
    input  wire logic              resetn,
    // axi4-lite write address
    input  wire logic [11:0]       s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    // axi4-lite write data
    input  wire caa_pkg::caa_word_t s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    // axi4-lite write response
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // axi4-lite read
    input  wire logic [11:0]       s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output caa_pkg::caa_word_t     s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // alarm sources, from the converter's own clock domain
    input  wire caa_pkg::caa_lanes_t laneFifoErr,
    input  wire caa_pkg::caa_lanes_t laneActive,
    input  wire logic              pllLocked,
    input  wire logic              linkInDataState,
    input  wire logic              linkStartup,
    input  wire logic              linkRealign,
    input  wire logic              sysrefRealign,
    input  wire logic              oscSync,
    input  wire logic              oscPhaseMismatch,
    input  wire logic              dividerMismatch,
    // outputs
    output logic                   status_output_pin,
    output logic                   link_enable,
    output logic                   irq
);
    import caa_pkg::*;

    // register state
    caa_flags_t alarmFlags_r;
    caa_flags_t alarm_mask_bits_r;
    caa_lanes_t laneErr_r;
    logic [3:0] ctrl_r;
    logic [1:0] irqStat_r;
    logic [1:0] irqMask_r;
    logic       summary_r;
    logic       linkEnPrev_r;

    // bus state
    logic [9:0] awIdx_r;
    logic       awHeld_r;
    caa_word_t  wData_r;
    logic [3:0] wStrb_r;
    logic       wHeld_r;
    logic [9:0] arIdx_r;
    logic       arHeld_r;

    function automatic logic known(input logic [9:0] idx);
        known = (idx == `CAA_IDX_SUMMARY) || (idx == `CAA_IDX_FLAGS)
             || (idx == `CAA_IDX_MASK) || (idx == `CAA_IDX_LANE)
             || (idx == `CAA_IDX_CTRL) || (idx == `CAA_IDX_IRQSTAT)
             || (idx == `CAA_IDX_IRQMASK);
    endfunction

    // write path: take address and data in either order
    wire doWrite = awHeld_r && wHeld_r && !s_axi_bvalid;
    wire wrFlags = doWrite && awIdx_r == `CAA_IDX_FLAGS && wStrb_r[0];
    wire wrMask  = doWrite && awIdx_r == `CAA_IDX_MASK && wStrb_r[0];
    wire wrLaneL = doWrite && awIdx_r == `CAA_IDX_LANE && wStrb_r[0];
    wire wrLaneH = doWrite && awIdx_r == `CAA_IDX_LANE && wStrb_r[1];
    wire wrCtrl  = doWrite && awIdx_r == `CAA_IDX_CTRL && wStrb_r[0];
    wire wrIrqM  = doWrite && awIdx_r == `CAA_IDX_IRQMASK && wStrb_r[0];

    wire doRead  = arHeld_r && !s_axi_rvalid;
    wire rdIrqSt = doRead && arIdx_r == `CAA_IDX_IRQSTAT;

    // soft reset is a self-clearing control bit
    wire softRst = ctrl_r[`CAA_CTRL_SOFTRST];
    wire linkEn  = ctrl_r[`CAA_CTRL_LINKEN];
    wire enc66   = ctrl_r[`CAA_CTRL_ENC66];

    // set terms, each the cause of its flag
    caa_lanes_t laneSet;
    caa_flags_t flagSet;
    assign laneSet = laneFifoErr & laneActive;
    assign flagSet[`CAA_BIT_FIFO]    = |laneSet;
    assign flagSet[`CAA_BIT_PLL]     = !pllLocked;
    assign flagSet[`CAA_BIT_LINK]    = enc66
        ? (linkStartup || linkRealign
           || (linkEn && !linkEnPrev_r))
        : (linkEn && !linkInDataState);
    assign flagSet[`CAA_BIT_REALIGN] = sysrefRealign;
    assign flagSet[`CAA_BIT_OSC]     = !linkEn || oscSync
                                     || oscPhaseMismatch;
    assign flagSet[`CAA_BIT_CLK]     = dividerMismatch;

    // clear terms; a set in the same cycle wins
    caa_flags_t flagClr;
    caa_lanes_t laneClr;
    assign flagClr = wrFlags ? wData_r[5:0] : '0;
    assign laneClr = {wrLaneH ? wData_r[15:8] : 8'h00,
                      wrLaneL ? wData_r[7:0] : 8'h00}
                   | {16{flagClr[`CAA_BIT_FIFO]}};

    caa_flags_t alarmFlags_nxt;
    caa_lanes_t laneErr_nxt;
    assign alarmFlags_nxt = softRst ? `CAA_FLAGS_RST
        : (alarmFlags_r & ~flagClr) | flagSet;
    assign laneErr_nxt = softRst ? `CAA_LANE_RST
        : (laneErr_r & ~laneClr) | laneSet;

    // the summary follows a mask written in the same cycle, so the
    // read-only bit never lags the mask register by a clock
    caa_flags_t alarmMask_nxt;
    assign alarmMask_nxt = softRst ? `CAA_MASK_RST
        : (wrMask ? wData_r[5:0] : alarm_mask_bits_r);
    wire summary_nxt = |(alarmFlags_nxt & ~alarmMask_nxt);

    // interrupt events: summary rising and any fifo error on a lane set in laneActive
    wire [1:0] irqEv = {|laneSet, summary_nxt & !summary_r};
    wire [1:0] irqStat_nxt = (rdIrqSt ? 2'h0 : irqStat_r) | irqEv;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            alarmFlags_r      <= `CAA_FLAGS_RST;
            alarm_mask_bits_r <= `CAA_MASK_RST;
            laneErr_r         <= `CAA_LANE_RST;
            summary_r         <= 1'b0;
            irqStat_r         <= 2'h0;
            linkEnPrev_r      <= 1'b0;
        end else begin
            alarmFlags_r      <= alarmFlags_nxt;
            laneErr_r         <= laneErr_nxt;
            summary_r         <= summary_nxt;
            irqStat_r         <= irqStat_nxt;
            linkEnPrev_r      <= linkEn;
            alarm_mask_bits_r <= alarmMask_nxt;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_r    <= 4'h0;
            irqMask_r <= 2'h0;
        end else begin
            if (wrCtrl)
                ctrl_r <= wData_r[3:0];
            else
                ctrl_r[`CAA_CTRL_SOFTRST] <= 1'b0;
            if (wrIrqM)
                irqMask_r <= wData_r[1:0];
        end
    end

    // pin outputs: each registered one cycle after its source register
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            status_output_pin <= 1'b0;
            link_enable       <= 1'b0;
            irq               <= 1'b0;
        end else begin
            status_output_pin <= ctrl_r[`CAA_CTRL_PINSEL]
                               & summary_r;
            link_enable       <= linkEn;
            irq               <= |(irqStat_r & irqMask_r);
        end
    end

    // axi write channel
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            awHeld_r      <= 1'b0;
            wHeld_r       <= 1'b0;
            awIdx_r       <= 10'h000;
            wData_r       <= '0;
            wStrb_r       <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `CAA_RESP_OKAY;
        end else begin
            s_axi_awready <= !awHeld_r && !s_axi_awready && s_axi_awvalid;
            s_axi_wready  <= !wHeld_r && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_r <= 1'b1;
                awIdx_r  <= s_axi_awaddr[11:2];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_r <= 1'b1;
                wData_r <= s_axi_wdata;
                wStrb_r <= s_axi_wstrb;
            end
            if (doWrite) begin
                awHeld_r     <= 1'b0;
                wHeld_r      <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= known(awIdx_r) ? `CAA_RESP_OKAY
                                               : `CAA_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // read data mux
    caa_word_t rdWord;
    always_comb begin
        rdWord = '0;
        unique case (arIdx_r)
            `CAA_IDX_SUMMARY: rdWord[0]    = summary_r;
            `CAA_IDX_FLAGS:   rdWord[5:0]  = alarmFlags_r;
            `CAA_IDX_MASK:    rdWord[5:0]  = alarm_mask_bits_r;
            `CAA_IDX_LANE:    rdWord[15:0] = laneErr_r;
            `CAA_IDX_CTRL:    rdWord[3:0]  = ctrl_r;
            `CAA_IDX_IRQSTAT: rdWord[1:0]  = irqStat_r;
            `CAA_IDX_IRQMASK: rdWord[1:0]  = irqMask_r;
            default:          rdWord       = '0;
        endcase
    end

    // axi read channel
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            arHeld_r      <= 1'b0;
            arIdx_r       <= 10'h000;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= `CAA_RESP_OKAY;
        end else begin
            s_axi_arready <= !arHeld_r && !s_axi_arready && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                arHeld_r <= 1'b1;
                arIdx_r  <= s_axi_araddr[11:2];
            end
            if (doRead) begin
                arHeld_r     <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rdWord;
                s_axi_rresp  <= known(arIdx_r) ? `CAA_RESP_OKAY
                                               : `CAA_RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // checks
    property p_summary;
        @(posedge ref_clk) disable iff (!resetn)
        summary_r == |(alarmFlags_r & ~alarm_mask_bits_r);
    endproperty
    a_summary: assert property (p_summary)
        else $error("summary bit disagrees with flags and mask");

    property p_pin;
        @(posedge ref_clk) disable iff (!resetn)
        ##1 status_output_pin == ($past(ctrl_r[`CAA_CTRL_PINSEL])
                                  && $past(summary_r));
    endproperty
    a_pin: assert property (p_pin)
        else $error("status pin does not follow summary");

    property p_fifo;
        @(posedge ref_clk) disable iff (!resetn)
        |(laneFifoErr & laneActive)
            |=> alarmFlags_r[`CAA_BIT_FIFO] && laneErr_r != 0;
    endproperty
    a_fifo: assert property (p_fifo)
        else $error("lane fifo error not flagged");

    property p_pll;
        @(posedge ref_clk) disable iff (!resetn)
        !pllLocked |=> alarmFlags_r[`CAA_BIT_PLL];
    endproperty
    a_pll: assert property (p_pll)
        else $error("pll unlock not flagged");

    property p_link8;
        @(posedge ref_clk) disable iff (!resetn)
        !enc66 && linkEn && !linkInDataState |=> alarmFlags_r[`CAA_BIT_LINK];
    endproperty
    a_link8: assert property (p_link8)
        else $error("link flag missing in 8b/10b mode");

    property p_link66;
        @(posedge ref_clk) disable iff (!resetn)
        enc66 && (linkStartup || linkRealign) |=> alarmFlags_r[`CAA_BIT_LINK];
    endproperty
    a_link66: assert property (p_link66)
        else $error("link flag missing in 64b/66b mode");

    property p_realign;
        @(posedge ref_clk) disable iff (!resetn)
        sysrefRealign |=> alarmFlags_r[`CAA_BIT_REALIGN];
    endproperty
    a_realign: assert property (p_realign)
        else $error("clock realignment not flagged");

    property p_osc;
        @(posedge ref_clk) disable iff (!resetn)
        (!linkEn || oscSync || oscPhaseMismatch)
            |=> alarmFlags_r[`CAA_BIT_OSC];
    endproperty
    a_osc: assert property (p_osc)
        else $error("oscillator upset not flagged");

    property p_clear;
        @(posedge ref_clk) disable iff (!resetn)
        wrFlags && wData_r[`CAA_BIT_CLK] && !dividerMismatch && !softRst
            |=> !alarmFlags_r[`CAA_BIT_CLK];
    endproperty
    a_clear: assert property (p_clear)
        else $error("write one did not clear divider flag");

    property p_sticky;
        @(posedge ref_clk) disable iff (!resetn)
        alarmFlags_r[`CAA_BIT_REALIGN]
            && !(wrFlags && wData_r[`CAA_BIT_REALIGN])
            |=> alarmFlags_r[`CAA_BIT_REALIGN];
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("realign flag dropped without a clear");

    property p_softrst;
        @(posedge ref_clk) disable iff (!resetn)
        softRst |=> alarmFlags_r == `CAA_FLAGS_RST
                    && alarm_mask_bits_r == `CAA_MASK_RST;
    endproperty
    a_softrst: assert property (p_softrst)
        else $error("soft reset did not restore flags and mask");
endmodule

// ===== hdl/caa_cfg.svh
`ifndef CAA_CFG_SVH
`define CAA_CFG_SVH
// register indices as printed; byte address is index times four
`define CAA_IDX_SUMMARY   10'h2c0
`define CAA_IDX_FLAGS     10'h2c1
`define CAA_IDX_MASK      10'h2c2
`define CAA_IDX_LANE      10'h2c4
`define CAA_IDX_CTRL      10'h2c8
`define CAA_IDX_IRQSTAT   10'h2c9
`define CAA_IDX_IRQMASK   10'h2ca
`define CAA_FLAGS_RST     6'h3f
`define CAA_MASK_RST      6'h3f
`define CAA_LANE_RST      16'hffff
`define CAA_BIT_FIFO      5
`define CAA_BIT_PLL       4
`define CAA_BIT_LINK      3
`define CAA_BIT_REALIGN   2
`define CAA_BIT_OSC       1
`define CAA_BIT_CLK       0
`define CAA_CTRL_PINSEL   0
`define CAA_CTRL_LINKEN   1
`define CAA_CTRL_ENC66    2
`define CAA_CTRL_SOFTRST  3
`define CAA_RESP_OKAY     2'h0
`define CAA_RESP_SLVERR   2'h2
`endif

// ===== hdl/caa_pkg.sv
package caa_pkg;
    typedef logic [5:0]  caa_flags_t;
    typedef logic [15:0] caa_lanes_t;
    typedef logic [31:0] caa_word_t;
endpackage
